// ==== pkg/clkgen_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define OFS_CFG_PRIMARY 4'h0
`define OFS_CFG_DIVIDER 4'h1
`define OFS_STATUS_ONE 4'h2
`define OFS_STATUS_TWO 4'h3
`define OFS_FILTER_HI 4'h4
`define OFS_FILTER_LO 4'h5
`define OFS_TRIM 4'h6
`define OFS_IRQ_STATUS 4'h7
`define OFS_IRQ_CLEAR 4'h8
`define OFS_IRQ_ENABLE 4'h9

// ****************************************************
// Primary control fields
// ****************************************************
`define PRI_HGO_BIT 7
`define PRI_RANGE_BIT 6
`define PRI_REF_OSCILLATOR_REQUEST_BIT 5
`define PRI_CLOCK_MODE_SELECT_HI 4
`define PRI_CLOCK_MODE_SELECT_LO 3
`define PRI_OSC_STOP_BIT 2
`define PRI_LOCD_BIT 1
`define PRI_WRITE_MASK 8'hfe

// ****************************************************
// Divider control fields
// ****************************************************
`define DIV_LOCK_LOSS_RESET_ENABLE_BIT 7
`define DIV_MFD_HI 6
`define DIV_MFD_LO 4
`define DIV_CLOCK_LOSS_RESET_ENABLE_BIT 3
`define DIV_RFD_HI 2
`define DIV_RFD_LO 0

// ****************************************************
// Status and interrupt fields
// ****************************************************
`define ST1_PEND_BIT 0
`define IRQ_LOCK_LOSS 0
`define IRQ_CLOCK_LOSS 1
`define IRQ_SETTLED 2
`define IRQ_MASK 8'h07
`define FILTER_HI_MASK 8'h0f

// ****************************************************
// Reset values
// ****************************************************
`define RST_CFG_PRIMARY 8'h00
`define RST_CFG_DIVIDER 8'h00
`define RST_FILTER 12'h000
`define RST_TRIM 8'h80

// ****************************************************
// Frequencies and timing
// ****************************************************
`define SCM_FREQ_HZ 32'd8000000
`define IRG_FREQ_HZ 32'd243000
`define IRG_DIVISOR 40'd7
`define PRESCALE_LOW 40'd64
`define PRESCALE_HIGH 40'd1
`define SETTLE_TIME_NS 2000
`define CLK_PERIOD_NS 8
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== pkg/clkgen_pkg.sv ====
// Types and decode functions of the clock generator
package clkgen_pkg;

  typedef enum logic [1:0] {
    SELF_CLOCKED = 2'b00,
    LOOP_LOCKED_INTERNAL = 2'b01,
    BYPASS_EXTERNAL = 2'b10,
    LOOP_LOCKED_EXTERNAL = 2'b11
  } gen_state_t;

  // Multiplier N = 4 + 2 * code
  function automatic logic [4:0] mult_factor(input logic [2:0] code);
    mult_factor = 5'd4 + {1'b0, code, 1'b0};
  endfunction

  // Divider R = 2 ** code, applied as a shift
  function automatic logic [2:0] div_shift(input logic [2:0] code);
    div_shift = code;
  endfunction

endpackage

// ==== pkg/clkgen_calc_if.sv ====
// Configuration and result between control and frequency calculator
`timescale 1ns/1ps
interface clkgen_calc_if;
  clkgen_pkg::gen_state_t state;
  logic range_high;
  logic [2:0] mult_code;
  logic [2:0] div_code;
  logic [31:0] ext_hz;
  logic [31:0] freq_hz;

  modport ctrl (
    output state, range_high, mult_code, div_code, ext_hz,
    input freq_hz
  );
  modport calc (
    input state, range_high, mult_code, div_code, ext_hz,
    output freq_hz
  );
endinterface

// ==== verilog/clkgen_freq_calc.sv ====
// Output frequency calculator of the clock generator
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module clkgen_freq_calc (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  clkgen_calc_if.calc cfg
);

  logic [39:0] base_hz;
  logic [39:0] prod_hz;
  logic [31:0] freq_next;

  always_comb begin
    base_hz = {8'h00, cfg.ext_hz};
    prod_hz = 40'h0;
    freq_next = `SCM_FREQ_HZ;
    case (cfg.state)
      clkgen_pkg::LOOP_LOCKED_EXTERNAL: begin
        // P is 64 on the low range, 1 on the high range
        base_hz = cfg.range_high ? base_hz * `PRESCALE_HIGH
                                 : base_hz * `PRESCALE_LOW;
        prod_hz = base_hz * {35'h0, clkgen_pkg::mult_factor(cfg.mult_code)};
        freq_next = prod_hz[31:0] >> clkgen_pkg::div_shift(cfg.div_code);
      end
      clkgen_pkg::LOOP_LOCKED_INTERNAL: begin
        // Internal loop always prescales by 64
        base_hz = ({8'h00, `IRG_FREQ_HZ} / `IRG_DIVISOR) * `PRESCALE_LOW;
        prod_hz = base_hz * {35'h0, clkgen_pkg::mult_factor(cfg.mult_code)};
        freq_next = prod_hz[31:0] >> clkgen_pkg::div_shift(cfg.div_code);
      end
      clkgen_pkg::BYPASS_EXTERNAL: begin
        freq_next = cfg.ext_hz >> clkgen_pkg::div_shift(cfg.div_code);
      end
      clkgen_pkg::SELF_CLOCKED: begin
        freq_next = `SCM_FREQ_HZ >> clkgen_pkg::div_shift(cfg.div_code);
      end
      default: begin
        freq_next = `SCM_FREQ_HZ;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cfg.freq_hz <= `SCM_FREQ_HZ;
    end else begin
      cfg.freq_hz <= freq_next;
    end
  end

endmodule // clkgen_freq_calc

// ==== verilog/clkgen_ctrl.sv ====
// Register file and mode control of the clock generator
// ****************************************************
// What this block does
// - After reset runs self-clocked at about 8 MHz, bus clock 4 MHz.
// - External locked mode: output is reference times P times N over R.
// - Internal locked mode: output is internal reference over 7, times 64 times N, over R.
// - Range bit 6: 0 gives prescale 64, 1 gives prescale 1.
// - Mode field bits 4:3: 11 external locked, 01 internal locked.
// - High gain bit 7 at 0 selects the low-power oscillator.
// - Bit 5 requests the crystal oscillator; ignored in internal locked mode.
// - Bit 0 of primary control reads zero and ignores writes.
// - Multiplier code bits 6:4: 000 gives 4, 011 gives 10.
// - Divider code bits 2:0: 000 divides by 1, 001 by 2.
// - Lock-loss reset enable at 0 gives an interrupt, not a reset.
// - Clock-loss reset enable at 0 gives an interrupt, not a reset.
// - Status one is read-only except the pending-flag clear.
// - Filter word holds 12 bits, loop-adjusted; top four bits read zero.
// - High gain bit takes only the first write after reset.
// - High gain acts only while the oscillator request bit is 1.
// ****************************************************
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module clkgen_ctrl (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_lock,
  input wire logic i_ref_ok,
  input wire logic [31:0] i_ext_ref_hz,
  input wire logic i_filter_upd,
  input wire logic [11:0] i_filter_loop,
  output logic [7:0] o_rdata,
  output logic [31:0] o_gen_freq_hz,
  output logic [31:0] o_bus_freq_hz,
  output logic [1:0] o_gen_state,
  output logic o_ref_osc_en,
  output logic o_high_gain_en,
  output logic o_osc_stop_en,
  output logic [11:0] o_filter,
  output logic [7:0] o_trim,
  output logic o_reset_req,
  output logic o_irq
);

  clkgen_calc_if calc_bus ();

  logic [7:0] primary_reg;
  logic [7:0] divider_reg;
  logic hgo_locked_reg;
  logic [11:0] filter_reg;
  logic [7:0] trim_reg;
  logic pend_reg;
  logic lock_loss_reg;
  logic clock_loss_reg;
  logic lock_prev_reg;
  logic ref_prev_reg;
  logic settled_reg;
  logic [15:0] settle_cnt_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] rdata_next;
  clkgen_pkg::gen_state_t state_reg;
  clkgen_pkg::gen_state_t state_next;
  logic [1:0] clock_mode_select;
  logic wr_primary;
  logic wr_divider;
  logic lock_loss_evt;
  logic clock_loss_evt;
  logic settled_evt;
  logic in_locked;
  logic ext_in_use;
  logic [7:0] irq_events;

  // ****************************************************
  // Decode
  // ****************************************************
  assign wr_primary = i_wr && (i_addr == `OFS_CFG_PRIMARY);
  assign wr_divider = i_wr && (i_addr == `OFS_CFG_DIVIDER);
  assign clock_mode_select = primary_reg[`PRI_CLOCK_MODE_SELECT_HI:`PRI_CLOCK_MODE_SELECT_LO];
  assign in_locked = (state_reg == clkgen_pkg::LOOP_LOCKED_EXTERNAL) ||
                     (state_reg == clkgen_pkg::LOOP_LOCKED_INTERNAL);
  assign ext_in_use = (state_reg == clkgen_pkg::LOOP_LOCKED_EXTERNAL) ||
                      (state_reg == clkgen_pkg::BYPASS_EXTERNAL);

  // ****************************************************
  // Control registers
  // ****************************************************
  // High gain bit is write-once; bits 6:1 stay writable, bit 0 stays zero
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      primary_reg <= `RST_CFG_PRIMARY;
      hgo_locked_reg <= 1'b0;
    end else if (wr_primary) begin
      primary_reg[6:1] <= i_wdata[6:1];
      primary_reg[0] <= 1'b0;
      hgo_locked_reg <= 1'b1;
      if (!hgo_locked_reg) begin
        primary_reg[`PRI_HGO_BIT] <= i_wdata[`PRI_HGO_BIT];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      divider_reg <= `RST_CFG_DIVIDER;
    end else if (wr_divider) begin
      divider_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      trim_reg <= `RST_TRIM;
    end else if (i_wr && (i_addr == `OFS_TRIM)) begin
      trim_reg <= i_wdata;
    end
  end

  // Loop wins over software while engaged; writes land in any cycle without a loop update
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      filter_reg <= `RST_FILTER;
    end else if (in_locked && i_filter_upd) begin
      filter_reg <= i_filter_loop;
    end else if (i_wr && (i_addr == `OFS_FILTER_HI)) begin
      filter_reg[11:8] <= i_wdata[3:0];
    end else if (i_wr && (i_addr == `OFS_FILTER_LO)) begin
      filter_reg[7:0] <= i_wdata;
    end
  end

  // ****************************************************
  // Mode state machine
  // ****************************************************
  always_comb begin
    state_next = state_reg;
    case (clock_mode_select)
      2'b00: begin
        state_next = clkgen_pkg::SELF_CLOCKED;
      end
      2'b01: begin
        state_next = clkgen_pkg::LOOP_LOCKED_INTERNAL;
      end
      2'b10: begin
        state_next = i_ref_ok ? clkgen_pkg::BYPASS_EXTERNAL
                              : clkgen_pkg::SELF_CLOCKED;
      end
      2'b11: begin
        // Falls back to self-clocked until the reference runs
        state_next = i_ref_ok ? clkgen_pkg::LOOP_LOCKED_EXTERNAL
                              : clkgen_pkg::SELF_CLOCKED;
      end
      default: begin
        state_next = clkgen_pkg::SELF_CLOCKED;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= clkgen_pkg::SELF_CLOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************
  // Oscillator controls
  // ****************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ref_osc_en <= 1'b0;
      o_high_gain_en <= 1'b0;
      o_osc_stop_en <= 1'b0;
    end else begin
      // Request is a don't care in internal locked mode
      o_ref_osc_en <= primary_reg[`PRI_REF_OSCILLATOR_REQUEST_BIT] &&
                      (state_next != clkgen_pkg::LOOP_LOCKED_INTERNAL);
      o_high_gain_en <= primary_reg[`PRI_HGO_BIT] &&
                        primary_reg[`PRI_REF_OSCILLATOR_REQUEST_BIT] &&
                        (state_next != clkgen_pkg::LOOP_LOCKED_INTERNAL);
      o_osc_stop_en <= primary_reg[`PRI_OSC_STOP_BIT];
    end
  end

  // ****************************************************
  // Loss events
  // ****************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      lock_prev_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      lock_prev_reg <= i_lock;
      ref_prev_reg <= i_ref_ok;
    end
  end

  assign lock_loss_evt = in_locked && lock_prev_reg && !i_lock;
  // Clock monitor is active when its disable bit is clear
  assign clock_loss_evt = ext_in_use && ref_prev_reg && !i_ref_ok &&
                          !primary_reg[`PRI_LOCD_BIT];

  // A reset enable of 1 turns the loss into a reset request
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_reset_req <= 1'b0;
    end else begin
      o_reset_req <= (lock_loss_evt && divider_reg[`DIV_LOCK_LOSS_RESET_ENABLE_BIT]) ||
                     (clock_loss_evt && divider_reg[`DIV_CLOCK_LOSS_RESET_ENABLE_BIT]);
    end
  end

  // Loss flags clear when lock or reference returns; sticky pending flag, a new event beats its clear
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pend_reg <= 1'b0;
      lock_loss_reg <= 1'b0;
      clock_loss_reg <= 1'b0;
    end else begin
      if ((lock_loss_evt && !divider_reg[`DIV_LOCK_LOSS_RESET_ENABLE_BIT]) ||
          (clock_loss_evt && !divider_reg[`DIV_CLOCK_LOSS_RESET_ENABLE_BIT])) begin
        pend_reg <= 1'b1;
      end else if (i_wr && (i_addr == `OFS_STATUS_ONE) &&
                   i_wdata[`ST1_PEND_BIT]) begin
        pend_reg <= 1'b0;
      end
      if (lock_loss_evt) begin
        lock_loss_reg <= 1'b1;
      end else if (i_lock && in_locked) begin
        lock_loss_reg <= 1'b0;
      end
      if (clock_loss_evt) begin
        clock_loss_reg <= 1'b1;
      end else if (i_ref_ok) begin
        clock_loss_reg <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Settled flag
  // ****************************************************
  // Counts lock held continuously; outside locked modes it counts up to settled regardless of lock
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      settle_cnt_reg <= 16'h0000;
      settled_reg <= 1'b0;
    end else if (in_locked && !i_lock) begin
      settle_cnt_reg <= 16'h0000;
      settled_reg <= 1'b0;
    end else if (settle_cnt_reg < 16'(`SETTLE_CYCLES)) begin
      settle_cnt_reg <= settle_cnt_reg + 16'h0001;
    end else begin
      settled_reg <= 1'b1;
    end
  end

  assign settled_evt = (settle_cnt_reg == 16'(`SETTLE_CYCLES)) &&
                       !settled_reg;

  // ****************************************************
  // Interrupts
  // ****************************************************
  always_comb begin
    irq_events = 8'h00;
    irq_events[`IRQ_LOCK_LOSS] = lock_loss_evt &&
                                 !divider_reg[`DIV_LOCK_LOSS_RESET_ENABLE_BIT];
    irq_events[`IRQ_CLOCK_LOSS] = clock_loss_evt &&
                                  !divider_reg[`DIV_CLOCK_LOSS_RESET_ENABLE_BIT];
    irq_events[`IRQ_SETTLED] = settled_evt;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      irq_status_reg <= 8'h00;
    end else if (i_wr && (i_addr == `OFS_IRQ_CLEAR)) begin
      // Set wins over a clear in the same cycle
      irq_status_reg <= (irq_status_reg & ~i_wdata) | irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      irq_enable_reg <= 8'h00;
    end else if (i_wr && (i_addr == `OFS_IRQ_ENABLE)) begin
      irq_enable_reg <= i_wdata & `IRQ_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // ****************************************************
  // Read path
  // ****************************************************
  always_comb begin
    rdata_next = 8'h00;
    case (i_addr)
      `OFS_CFG_PRIMARY: rdata_next = primary_reg & `PRI_WRITE_MASK;
      `OFS_CFG_DIVIDER: rdata_next = divider_reg;
      `OFS_STATUS_ONE: rdata_next = {state_reg, i_ref_ok, i_lock,
                                     lock_loss_reg, clock_loss_reg,
                                     1'b0, pend_reg};
      `OFS_STATUS_TWO: rdata_next = {7'h00, settled_reg};
      `OFS_FILTER_HI: rdata_next = {4'h0, filter_reg[11:8]};
      `OFS_FILTER_LO: rdata_next = filter_reg[7:0];
      `OFS_TRIM: rdata_next = trim_reg;
      `OFS_IRQ_STATUS: rdata_next = irq_status_reg;
      `OFS_IRQ_ENABLE: rdata_next = irq_enable_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ****************************************************
  // Frequency outputs
  // ****************************************************
  assign calc_bus.state = state_reg;
  assign calc_bus.range_high = primary_reg[`PRI_RANGE_BIT];
  assign calc_bus.mult_code = divider_reg[`DIV_MFD_HI:`DIV_MFD_LO];
  assign calc_bus.div_code = divider_reg[`DIV_RFD_HI:`DIV_RFD_LO];
  assign calc_bus.ext_hz = i_ext_ref_hz;

  clkgen_freq_calc u_calc (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .cfg(calc_bus.calc)
  );

  // One extra stage so both frequency outputs move together
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_gen_freq_hz <= `SCM_FREQ_HZ;
      o_bus_freq_hz <= `SCM_FREQ_HZ >> 1;
      o_gen_state <= 2'b00;
    end else begin
      o_gen_freq_hz <= calc_bus.freq_hz;
      o_bus_freq_hz <= calc_bus.freq_hz >> 1;
      o_gen_state <= state_reg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_filter <= `RST_FILTER;
      o_trim <= `RST_TRIM;
    end else begin
      o_filter <= filter_reg;
      o_trim <= trim_reg;
    end
  end

endmodule // clkgen_ctrl

// ==== verification/clkgen_ctrl_monitor.sv ====
// Port-level assertions of the clock generator control block
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module clkgen_ctrl_monitor (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_lock,
  input wire logic i_ref_ok,
  input wire logic i_filter_upd,
  input wire logic [11:0] i_filter_loop,
  input wire logic [7:0] o_rdata,
  input wire logic [31:0] o_gen_freq_hz,
  input wire logic [31:0] o_bus_freq_hz,
  input wire logic [1:0] o_gen_state,
  input wire logic o_ref_osc_en,
  input wire logic o_high_gain_en,
  input wire logic [11:0] o_filter,
  input wire logic [7:0] o_trim,
  input wire logic o_reset_req,
  input wire logic o_irq
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  // ****************************************************
  // Assertions
  // ****************************************************
  AST_RESET_SELF: assert property ($past(i_sys_rst) |->
    o_gen_state == 2'b00 && o_gen_freq_hz == `SCM_FREQ_HZ &&
    o_trim == `RST_TRIM) else $error("not self-clocked after reset");
  // Two stable samples, so either bus-clock latency is accepted
  AST_BUS_HALF: assert property ($stable(o_gen_freq_hz) [*2] |->
    o_bus_freq_hz == o_gen_freq_hz >> 1) else $error("bus not half");
  AST_EXT_MODE: assert property (i_wr && i_addr == `OFS_CFG_PRIMARY &&
    i_wdata[4:3] == 2'b11 && i_ref_ok ##1 i_ref_ok |->
    ##2 o_gen_state == 2'b11) else $error("external mode not entered");
  AST_INT_MODE: assert property (i_wr && i_addr == `OFS_CFG_PRIMARY &&
    i_wdata[4:3] == 2'b01 |-> ##3 o_gen_state == 2'b01)
    else $error("internal mode not entered");
  AST_BIT0_ZERO: assert property ($past(i_rd) &&
    $past(i_addr) == `OFS_CFG_PRIMARY |-> !o_rdata[0])
    else $error("primary bit 0 not zero");
  AST_REF_OSCILLATOR_REQUEST_WRITE: assert property (i_wr && i_addr == `OFS_CFG_PRIMARY |->
    ##2 o_ref_osc_en == ($past(i_wdata[5], 2) &&
    $past(i_wdata[4:3], 2) != 2'b01))
    else $error("oscillator request wrong");
  AST_FILTER_LOOP: assert property (i_filter_upd |->
    ##2 o_filter == $past(i_filter_loop, 2)) else $error("filter not taken");
  AST_HGO_GATED: assert property (o_high_gain_en &&
    $stable(o_ref_osc_en) && $stable(o_gen_state) |->
    o_ref_osc_en && o_gen_state != 2'b01) else $error("high gain ungated");
  AST_RESET_PULSE: assert property (o_reset_req |=> !o_reset_req)
    else $error("reset request longer than one cycle");
  AST_RESET_CAUSE: assert property (o_reset_req |->
    !i_lock || !i_ref_ok) else $error("reset request without loss");
  AST_IRQ_MASKED: assert property (i_wr &&
    i_addr == `OFS_IRQ_ENABLE && i_wdata[2:0] == 3'b000 |-> ##2 !o_irq)
    else $error("interrupt not masked");
  cover property (o_reset_req);
  cover property (o_irq);
  cover property (o_high_gain_en);
endmodule // clkgen_ctrl_monitor

bind clkgen_ctrl clkgen_ctrl_monitor i_clkgen_ctrl_monitor (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_lock(i_lock),
  .i_ref_ok(i_ref_ok), .i_filter_upd(i_filter_upd),
  .i_filter_loop(i_filter_loop), .o_rdata(o_rdata),
  .o_gen_freq_hz(o_gen_freq_hz), .o_bus_freq_hz(o_bus_freq_hz),
  .o_gen_state(o_gen_state), .o_ref_osc_en(o_ref_osc_en),
  .o_high_gain_en(o_high_gain_en), .o_filter(o_filter), .o_trim(o_trim),
  .o_reset_req(o_reset_req), .o_irq(o_irq)
);

// ==== verification/tb_top.sv ====
// Self-checking bench of the clock generator control block
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module tb_top;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_lock = 1'b1, i_ref_ok = 1'b1, i_filter_upd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, o_trim, v;
  logic [31:0] i_ext_ref_hz = 32'd32000, o_gen_freq_hz, o_bus_freq_hz;
  logic [31:0] seed = 32'hc4336d3a;
  logic [11:0] i_filter_loop = 12'h000, o_filter;
  logic [1:0] o_gen_state;
  logic o_ref_osc_en, o_high_gain_en, o_osc_stop_en, o_reset_req, o_irq;
  int mismatches = 0, checks = 0, high_gain_osc_select = -1, pulses;
  logic [7:0] cfg_pri[3] = '{8'hb9, 8'h78, 8'h28};
  logic [7:0] cfg_div[3] = '{8'h00, 8'h30, 8'h31};
  int cfg_ext[3] = '{32000, 4000000, 4000000};

  clkgen_ctrl i_clkgen_ctrl (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_lock(i_lock), .i_ref_ok(i_ref_ok), .i_ext_ref_hz(i_ext_ref_hz),
    .i_filter_upd(i_filter_upd), .i_filter_loop(i_filter_loop),
    .o_rdata(o_rdata), .o_gen_freq_hz(o_gen_freq_hz),
    .o_bus_freq_hz(o_bus_freq_hz), .o_gen_state(o_gen_state),
    .o_ref_osc_en(o_ref_osc_en), .o_high_gain_en(o_high_gain_en),
    .o_osc_stop_en(o_osc_stop_en), .o_filter(o_filter), .o_trim(o_trim),
    .o_reset_req(o_reset_req), .o_irq(o_irq));

  always #4 i_mclk = ~i_mclk;

  // ****************************************************
  // Model and bus tasks
  // ****************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Shift equals divide: R is a power of two, truncation matches
  function automatic int efreq(input logic [7:0] p, dv, input int ext);
    int n;
    n = 4 + 2 * dv[6:4];
    if (p[4:3] == 2'b01) efreq = (243000 / 7) * 64 * n >> dv[2:0];
    else efreq = ext * (p[6] ? 1 : 64) * n >> dv[2:0];
  endfunction
  task automatic chk8(input logic [7:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk8({7'h0, o_irq}, {7'h0, e}, "irq line");
  endtask
  task automatic setup(input logic [7:0] p, dv, input int ext);
    logic [7:0] q;
    @(posedge i_mclk);
    i_ext_ref_hz <= ext;
    wr(`OFS_CFG_DIVIDER, dv);
    wr(`OFS_CFG_PRIMARY, p);
    if (high_gain_osc_select < 0) high_gain_osc_select = p[7];
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    chk32(o_gen_freq_hz, efreq(p, dv, ext), "freq");
    chk32(o_bus_freq_hz, efreq(p, dv, ext) / 2, "bus half");
    chk8({6'h0, o_gen_state}, {6'h0, p[4:3]}, "mode");
    chk8({7'h0, o_ref_osc_en},
      {7'h0, p[5] & (p[4:3] != 2'b01)}, "osc request");
    chk8({7'h0, o_high_gain_en},
      {7'h0, high_gain_osc_select[0] & p[5] & (p[4:3] != 2'b01)}, "high gain");
    rd(`OFS_CFG_PRIMARY, q);
    chk8(q, {high_gain_osc_select[0], p[6:1], 1'b0}, "primary");
    rd(`OFS_CFG_DIVIDER, q);
    chk8(q, dv, "divider");
  endtask
  // Lock loss (k 0) or clock loss (k 1) with reset enable re
  task automatic loss(input int k, re);
    wr(`OFS_CFG_DIVIDER, k ? {4'h0, re[0], 3'h0} : {re[0], 7'h0});
    wr(`OFS_IRQ_CLEAR, 8'h07);
    wr(`OFS_STATUS_ONE, 8'h01);
    @(posedge i_mclk);
    if (k) i_ref_ok <= 1'b0;
    else i_lock <= 1'b0;
    pulses = 0;
    repeat (6) begin
      @(negedge i_mclk);
      if (o_reset_req === 1'b1) pulses++;
    end
    chk8(pulses[7:0], re[7:0], "reset pulses");
    rd(`OFS_STATUS_ONE, v);
    chk8(v, k ? {7'h0a, !re[0]} : {7'h74, !re[0]}, "status one");
    if (!re) begin
      rd(`OFS_IRQ_STATUS, v);
      chk8(v & 8'h03, 8'h01 << k, "irq status");
      irq_is(1'b1);
      wr(`OFS_IRQ_ENABLE, 8'h00);
      irq_is(1'b0);
      wr(`OFS_IRQ_ENABLE, 8'h03);
      irq_is(1'b1);
      wr(`OFS_IRQ_CLEAR, 8'h01 << k);
      irq_is(1'b0);
    end
    @(posedge i_mclk);
    i_lock <= 1'b1;
    i_ref_ok <= 1'b1;
    repeat (8) @(posedge i_mclk);
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  initial begin
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(negedge i_mclk);
    chk32(o_gen_freq_hz, `SCM_FREQ_HZ, "reset freq");
    chk32(o_bus_freq_hz, `SCM_FREQ_HZ / 2, "bus freq");
    for (int a = 0; a < 16; a++) begin
      if (a inside {2, 3, 7}) continue;
      rd(a[3:0], v);
      chk8(v, (a == 6) ? `RST_TRIM : 8'h00, "reset value");
    end
    v = 8'h00;
    for (int i = 0; i < 120 && v[0] !== 1'b1; i++) rd(`OFS_STATUS_TWO, v);
    wr(`OFS_STATUS_TWO, 8'h00);
    rd(`OFS_STATUS_TWO, v);
    chk8(v, 8'h01, "status two");
    wr(`OFS_STATUS_ONE, 8'hfe);
    rd(`OFS_STATUS_ONE, v);
    chk8(v, 8'h30, "status one");
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      if (i < 3) setup(cfg_pri[i], cfg_div[i], cfg_ext[i]);
      else setup({seed[7:5], seed[0] ? 2'b11 : 2'b01, seed[2:1], seed[3]},
        {1'b0, seed[14:12], 1'b0, seed[10:8]}, 30000 + seed[31:16]);
    end
    @(posedge i_mclk);
    i_filter_upd <= 1'b1;
    i_filter_loop <= seed[11:0];
    @(posedge i_mclk);
    i_filter_upd <= 1'b0;
    rd(`OFS_FILTER_HI, v);
    chk8(v, {4'h0, seed[11:8]}, "filter hi");
    rd(`OFS_FILTER_LO, v);
    chk8(v, seed[7:0], "filter lo");
    chk32({20'h0, o_filter}, {20'h0, seed[11:0]}, "filter out");
    wr(`OFS_FILTER_HI, 8'hff);
    rd(`OFS_FILTER_HI, v);
    chk8(v, 8'h0f, "filter mask");
    // Trim under a doubled divider so the output cannot overshoot
    wr(`OFS_CFG_DIVIDER, 8'h01);
    wr(`OFS_TRIM, seed[23:16]);
    wr(`OFS_CFG_DIVIDER, 8'h00);
    rd(`OFS_TRIM, v);
    chk8(v, seed[23:16], "trim");
    chk8(o_trim, seed[23:16], "trim out");
    setup(8'h38, 8'h00, 32000);
    wr(`OFS_IRQ_ENABLE, 8'h03);
    for (int k = 0; k < 2; k++)
      for (int re = 0; re < 2; re++) loss(k, re);
    print_verdict();
  end

  initial begin
    #(25000 * 8);
    mismatches++;
    print_verdict();
  end
endmodule // tb_top
